// ### rtl/cdag_regs.svh
// register offsets, field positions, reset values and timing counts for the decode block
`ifndef CDAG_REGS_SVH
`define CDAG_REGS_SVH

// clock rate and time-to-cycle conversion, rounded up to whole cycles
`define CDAG_CLK_MHZ 40
`define CDAG_CYC(t_ns) ((((t_ns) * `CDAG_CLK_MHZ) + 999) / 1000)

// register byte offsets on the apb slave
`define CDAG_OFF_CTRL 12'h000
`define CDAG_OFF_STATUS 12'h004
`define CDAG_OFF_EA 12'h008
`define CDAG_OFF_OP 12'h00c

// control register fields and reset value
`define CDAG_CTRL_CFG8K_BIT 0
`define CDAG_CTRL_RESUME_BIT 1
`define CDAG_CTRL_RESET 1'h0

// status register fields
`define CDAG_ST_HALT_BIT 0
`define CDAG_ST_INTEN_BIT 1
`define CDAG_ST_BANK_BIT 2
`define CDAG_ST_BUSY_BIT 3
`define CDAG_ST_ZSAVE_LSB 4

// op register field position of the cycle count
`define CDAG_OP_CYC_LSB 16

// execution times in ns
`define CDAG_T_LS_NS 3390
`define CDAG_T_LS_IND_NS 5090
`define CDAG_T_ARITH_NS 7630
`define CDAG_T_ARITH_IND_NS 9330
`define CDAG_T_INCR_NS 9330
`define CDAG_T_INCR_IND_NS 11020
`define CDAG_T_JSPC_NS 4660
`define CDAG_T_JSPC_IND_NS 6360
`define CDAG_T_IO_NS 4660
`define CDAG_T_SHIFT_BASE_NS 3400
`define CDAG_T_SHIFT_STEP_NS 424
`define CDAG_T_SKIP_NS 3390
`define CDAG_T_GEN_SHORT_NS 2540
`define CDAG_T_GEN_MID_NS 3390
`define CDAG_T_GEN_LONG_NS 7630

// derived cycle counts
`define CDAG_C_LS `CDAG_CYC(`CDAG_T_LS_NS)
`define CDAG_C_LS_IND `CDAG_CYC(`CDAG_T_LS_IND_NS)
`define CDAG_C_ARITH `CDAG_CYC(`CDAG_T_ARITH_NS)
`define CDAG_C_ARITH_IND `CDAG_CYC(`CDAG_T_ARITH_IND_NS)
`define CDAG_C_INCR `CDAG_CYC(`CDAG_T_INCR_NS)
`define CDAG_C_INCR_IND `CDAG_CYC(`CDAG_T_INCR_IND_NS)
`define CDAG_C_JSPC `CDAG_CYC(`CDAG_T_JSPC_NS)
`define CDAG_C_JSPC_IND `CDAG_CYC(`CDAG_T_JSPC_IND_NS)
`define CDAG_C_IO `CDAG_CYC(`CDAG_T_IO_NS)
`define CDAG_C_SKIP `CDAG_CYC(`CDAG_T_SKIP_NS)
`define CDAG_C_GEN_SHORT `CDAG_CYC(`CDAG_T_GEN_SHORT_NS)
`define CDAG_C_GEN_MID `CDAG_CYC(`CDAG_T_GEN_MID_NS)
`define CDAG_C_GEN_LONG `CDAG_CYC(`CDAG_T_GEN_LONG_NS)

`endif

// ### rtl/cdag_pkg.sv
// types shared by the decode and address generation block
package cdag_pkg;

	typedef enum logic [2:0] {
		cdag_cl_memref = 3'h0,
		cdag_cl_io = 3'h1,
		cdag_cl_shift = 3'h2,
		cdag_cl_skip = 3'h3,
		cdag_cl_generic = 3'h4,
		cdag_cl_undef = 3'h5
	} cdag_class_t;

	typedef enum logic [2:0] {
		cdag_mr_none = 3'h0,
		cdag_mr_load_acc = 3'h1,
		cdag_mr_store_acc = 3'h2,
		cdag_mr_jump = 3'h3,
		cdag_mr_add = 3'h4,
		cdag_mr_and_acc = 3'h5,
		cdag_mr_incr_replace_skip = 3'h6,
		cdag_mr_jump_store_pc = 3'h7
	} cdag_mr_op_t;

	typedef enum logic [2:0] {
		cdag_io_input_to_acc = 3'h0,
		cdag_io_skip_if_device_set = 3'h1,
		cdag_io_output_from_acc = 3'h2,
		cdag_io_output_control_pulse = 3'h3,
		cdag_io_set_int_mask = 3'h4
	} cdag_io_op_t;

	typedef enum logic [1:0] {
		cdag_sh_logical_right_shift = 2'h0,
		cdag_sh_arith_right_shift = 2'h1,
		cdag_sh_rotate_acc_right = 2'h2,
		cdag_sh_none = 2'h3
	} cdag_shift_op_t;

	typedef enum logic [3:0] {
		cdag_gn_none = 4'h0,
		cdag_gn_halt_op = 4'h1,
		cdag_gn_ones_complement_acc = 4'h2,
		cdag_gn_twos_complement_acc = 4'h3,
		cdag_gn_stall_online = 4'h4,
		cdag_gn_bank_to_acc = 4'h5,
		cdag_gn_int_save = 4'h6,
		cdag_gn_overflow_to_acc = 4'h7,
		cdag_gn_acc_to_bank = 4'h8,
		cdag_gn_int_return = 4'h9,
		cdag_gn_int_enable_op = 4'ha,
		cdag_gn_int_inhibit_op = 4'hb,
		cdag_gn_clear_acc = 4'hc
	} cdag_gen_op_t;

	typedef enum logic [1:0] {
		cdag_st_idle = 2'h0,
		cdag_st_ind = 2'h1,
		cdag_st_exec = 2'h2,
		cdag_st_done = 2'h3
	} cdag_state_t;

	// one decoded instruction
	typedef struct packed {
		cdag_class_t cls;
		cdag_mr_op_t mr_op;
		logic indirect;
		logic sector;
		cdag_io_op_t io_op;
		logic [5:0] device;
		cdag_shift_op_t shift_op;
		logic [3:0] shift_n;
		logic [2:0] skip_cond;
		logic skip_inv;
		cdag_gen_op_t gen_op;
	} cdag_dec_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} cdag_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cdag_apb_rsp_t;

	// all state of the core
	typedef struct packed {
		cdag_state_t st;
		logic [11:0] word;
		logic [12:0] pc;
		cdag_dec_t dec;
		logic [12:0] ea;
		logic [11:0] acc;
		logic acc_we;
		logic skip;
		logic bank;
		logic [1:0] zsave;
		logic int_en;
		logic halt;
		logic cfg_8k;
		logic [9:0] cycles;
		logic [9:0] elapsed;
		logic [31:0] rdata;
	} cdag_core_s_t;

endpackage : cdag_pkg

// ### rtl/cdag_timer.sv
// down counter that times one instruction's execution
`timescale 1ns/10ps
module cdag_timer #(
	parameter int W = 10
) (
	input wire logic clk_in, // cpu clock
	input wire logic reset_n_in, // master clear, active low
	input wire logic load_in, // load a new count
	input wire logic [W-1:0] load_val_in, // instruction cycles minus two
	output logic expired_out // count has reached zero
);
	typedef struct packed {
		logic [W-1:0] count;
	} cdag_tmr_s_t;

	cdag_tmr_s_t s_q;
	cdag_tmr_s_t s_d;

	// load wins over counting; holds at zero
	always_comb begin
		s_d = s_q;
		if (load_in) begin
			s_d.count = load_val_in;
		end else if (s_q.count != '0) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expired_out = (s_q.count == '0);
endmodule : cdag_timer

// ### rtl/cdag_core.sv
// instruction decode and effective address generation with apb status access
// How it works
// - memory-reference words carry a 7-bit direct field reaching 128 words
// - memory is split in 128-word sectors, 32 in 4K and 64 in 8K
// - sector bit zero picks a primary sector, one picks the instruction's sector
// - indirect bit one takes the 12-bit word at the direct address as address
// - lower bank with bank bit zero addresses exactly like 4K mode
// - upper bank with bank bit one adds 10000 octal to every address
// - lower bank, bank bit one: direct stays low, indirect gets 10000 octal added
// - upper bank, bank bit zero: direct stays upper, indirect falls low
// - memory opcodes 1 to 7 decode to the seven memory operations
// - codes 40xx to 43xx decode the device operations, 4301 sets mask
// - shift time is a base plus a per-position step times the count
// - skip codes test sign, zero and overflow, 03xx skips on the inverse
// - generic codes halt, complement, negate, clear and stall until on-line
// - generic codes copy overflow, save, return, enable and inhibit interrupts
// - generic codes copy bank to accumulator and accumulator to bank
// - direct load, store, jump take 3.39 us, indirect 5.09 us
// - add and and 7.63/9.33, increment-skip 9.33/11.02, jump-store 4.66/6.36 us
// - every device operation takes 4.66 us
// - in 8K the bank register forms the top bit of an indirect address
`timescale 1ns/10ps
`include "cdag_regs.svh"
module cdag_core (
	input wire logic clk_in, // cpu clock, 40 MHz
	input wire logic reset_n_in, // master clear, active low, asynchronous
	input wire cdag_pkg::cdag_apb_req_t apb_in, // apb request
	output cdag_pkg::cdag_apb_rsp_t apb_out, // apb response
	input wire logic instr_valid_in, // instruction word offered
	output logic instr_ready_out, // instruction taken this cycle
	input wire logic [11:0] instr_word_in, // instruction word
	input wire logic [12:0] pc_in, // location of the instruction
	input wire logic [11:0] acc_in, // accumulator contents
	input wire logic overflow_in, // overflow flip-flop
	input wire logic online_in, // on-line condition for the stall op
	output logic mem_rd_out, // indirect word read request
	output logic [12:0] mem_addr_out, // indirect word address
	input wire logic mem_ack_in, // read data valid
	input wire logic [11:0] mem_rdata_in, // read data
	output logic done_out, // execution complete, one cycle
	output logic busy_out, // instruction in progress
	output cdag_pkg::cdag_dec_t dec_out, // decoded instruction
	output logic [12:0] ea_out, // effective address
	output logic [11:0] acc_res_out, // new accumulator value
	output logic acc_we_out, // acc_res_out is to be written
	output logic skip_out // skip the next instruction
);
	cdag_pkg::cdag_core_s_t s_q;
	cdag_pkg::cdag_core_s_t s_d;
	logic tmr_load;
	logic [9:0] tmr_val;
	logic tmr_expired;
	logic apb_wr;
	logic apb_setup;
	logic resume;
	logic take;
	cdag_pkg::cdag_dec_t dec_new;
	logic [12:0] direct_addr;
	logic [11:0] acc_new;
	logic acc_we_new;
	logic skip_new;
	logic bank_eff;

	// split a word into its group and fields
	function automatic cdag_pkg::cdag_dec_t cdag_decode(input logic [11:0] w);
		cdag_pkg::cdag_dec_t d;
		d = '0;
		d.cls = cdag_pkg::cdag_cl_undef;
		d.shift_op = cdag_pkg::cdag_sh_none;
		if (w[10:8] != 3'h0) begin
			d.cls = cdag_pkg::cdag_cl_memref;
			d.mr_op = cdag_pkg::cdag_mr_op_t'(w[10:8]);
			d.indirect = w[11];
			d.sector = w[7];
		end else if (w[11]) begin
			d.cls = cdag_pkg::cdag_cl_io;
			d.device = w[5:0];
			if (w[7:6] == 2'h3 && w[5:0] == 6'h01) begin
				d.io_op = cdag_pkg::cdag_io_set_int_mask;
			end else begin
				d.io_op = cdag_pkg::cdag_io_op_t'({1'b0, w[7:6]});
			end
		end else begin
			case (w[7:6])
				2'h1: begin
					d.shift_op = cdag_pkg::cdag_shift_op_t'(w[5:4]);
					d.shift_n = w[3:0];
					d.cls = (w[5:4] == 2'h3) ? cdag_pkg::cdag_cl_undef : cdag_pkg::cdag_cl_shift;
				end
				2'h2, 2'h3: begin
					d.skip_cond = w[2:0];
					d.skip_inv = w[6];
					if (w[5:3] == 3'h0 && w[2:0] <= 3'h4) begin
						d.cls = cdag_pkg::cdag_cl_skip;
					end
				end
				default: begin
					d.cls = cdag_pkg::cdag_cl_generic;
					case (w[5:0])
						6'h00: d.gen_op = cdag_pkg::cdag_gn_halt_op;
						6'h03: d.gen_op = cdag_pkg::cdag_gn_ones_complement_acc;
						6'h05: d.gen_op = cdag_pkg::cdag_gn_twos_complement_acc;
						6'h11: d.gen_op = cdag_pkg::cdag_gn_stall_online;
						6'h12: d.gen_op = cdag_pkg::cdag_gn_bank_to_acc;
						6'h14: d.gen_op = cdag_pkg::cdag_gn_int_save;
						6'h18: d.gen_op = cdag_pkg::cdag_gn_overflow_to_acc;
						6'h21: d.gen_op = cdag_pkg::cdag_gn_acc_to_bank;
						6'h22: d.gen_op = cdag_pkg::cdag_gn_int_return;
						6'h24: d.gen_op = cdag_pkg::cdag_gn_int_enable_op;
						6'h28: d.gen_op = cdag_pkg::cdag_gn_int_inhibit_op;
						6'h30: d.gen_op = cdag_pkg::cdag_gn_clear_acc;
						default: d.cls = cdag_pkg::cdag_cl_undef;
					endcase
				end
			endcase
		end
		return d;
	endfunction : cdag_decode

	// execution time of one decoded instruction in clock cycles
	function automatic logic [9:0] cdag_cycles(input cdag_pkg::cdag_dec_t d);
		int t;
		t = `CDAG_C_GEN_SHORT;
		case (d.cls)
			cdag_pkg::cdag_cl_memref: begin
				case (d.mr_op)
					cdag_pkg::cdag_mr_add, cdag_pkg::cdag_mr_and_acc:
						t = d.indirect ? `CDAG_C_ARITH_IND : `CDAG_C_ARITH;
					cdag_pkg::cdag_mr_incr_replace_skip:
						t = d.indirect ? `CDAG_C_INCR_IND : `CDAG_C_INCR;
					cdag_pkg::cdag_mr_jump_store_pc:
						t = d.indirect ? `CDAG_C_JSPC_IND : `CDAG_C_JSPC;
					default:
						t = d.indirect ? `CDAG_C_LS_IND : `CDAG_C_LS;
				endcase
			end
			cdag_pkg::cdag_cl_io: t = `CDAG_C_IO;
			cdag_pkg::cdag_cl_shift:
				t = `CDAG_CYC(`CDAG_T_SHIFT_BASE_NS + `CDAG_T_SHIFT_STEP_NS * int'(d.shift_n));
			cdag_pkg::cdag_cl_skip: t = `CDAG_C_SKIP;
			cdag_pkg::cdag_cl_generic: begin
				case (d.gen_op)
					cdag_pkg::cdag_gn_ones_complement_acc, cdag_pkg::cdag_gn_twos_complement_acc:
						t = `CDAG_C_GEN_LONG;
					cdag_pkg::cdag_gn_stall_online, cdag_pkg::cdag_gn_bank_to_acc,
					cdag_pkg::cdag_gn_int_save, cdag_pkg::cdag_gn_overflow_to_acc:
						t = `CDAG_C_GEN_MID;
					default: t = `CDAG_C_GEN_SHORT;
				endcase
			end
			default: t = `CDAG_C_GEN_SHORT;
		endcase
		return t[9:0];
	endfunction : cdag_cycles

	// in 4K mode the bank register takes no part in addressing
	assign bank_eff = s_q.cfg_8k & s_q.bank;
	assign take = instr_valid_in && (s_q.st == cdag_pkg::cdag_st_idle) && !s_q.halt;
	assign dec_new = cdag_decode(instr_word_in);

	// direct address: bank and sector from the instruction's location or a primary sector
	always_comb begin
		direct_addr = {s_q.cfg_8k & pc_in[12], 5'h00, instr_word_in[6:0]};
		if (instr_word_in[7]) begin
			direct_addr[11:7] = pc_in[11:7];
		end
	end

	// accumulator and skip results, taken from the values seen at issue
	always_comb begin
		acc_new = acc_in;
		acc_we_new = 1'b0;
		skip_new = 1'b0;
		case (dec_new.cls)
			cdag_pkg::cdag_cl_shift: begin
				acc_we_new = 1'b1;
				case (dec_new.shift_op)
					cdag_pkg::cdag_sh_logical_right_shift: acc_new = acc_in >> dec_new.shift_n;
					cdag_pkg::cdag_sh_arith_right_shift:
						acc_new = 12'($signed(acc_in) >>> dec_new.shift_n);
					default: acc_new = 12'({acc_in, acc_in, acc_in} >> dec_new.shift_n);
				endcase
			end
			cdag_pkg::cdag_cl_skip: begin
				case (dec_new.skip_cond)
					3'h1: skip_new = acc_in[11];
					3'h2: skip_new = (acc_in == 12'h000);
					3'h3: skip_new = acc_in[11] || (acc_in == 12'h000);
					3'h4: skip_new = overflow_in;
					default: skip_new = 1'b0;
				endcase
				skip_new = skip_new ^ dec_new.skip_inv;
			end
			cdag_pkg::cdag_cl_generic: begin
				acc_we_new = 1'b1;
				case (dec_new.gen_op)
					cdag_pkg::cdag_gn_ones_complement_acc: acc_new = ~acc_in;
					cdag_pkg::cdag_gn_twos_complement_acc: acc_new = 12'h000 - acc_in;
					cdag_pkg::cdag_gn_clear_acc: acc_new = 12'h000;
					cdag_pkg::cdag_gn_overflow_to_acc: acc_new = {11'h000, overflow_in};
					cdag_pkg::cdag_gn_bank_to_acc: acc_new = {11'h000, bank_eff};
					default: acc_we_new = 1'b0;
				endcase
			end
			default: acc_we_new = 1'b0;
		endcase
	end

	assign apb_setup = apb_in.psel && !apb_in.penable;
	assign apb_wr = apb_in.psel && apb_in.penable && apb_in.pwrite;
	assign resume = apb_wr && (apb_in.paddr == `CDAG_OFF_CTRL) && apb_in.pwdata[`CDAG_CTRL_RESUME_BIT];

	// register bus, sequencing and the effects applied at completion
	always_comb begin
		s_d = s_q;
		tmr_load = 1'b0;
		tmr_val = 10'h000;
		if (s_q.elapsed != 10'h3ff) begin
			s_d.elapsed = s_q.elapsed + 10'h001;
		end
		if (apb_setup) begin
			s_d.rdata = 32'h0000_0000;
			case (apb_in.paddr)
				`CDAG_OFF_CTRL: s_d.rdata[`CDAG_CTRL_CFG8K_BIT] = s_q.cfg_8k;
				`CDAG_OFF_STATUS: begin
					s_d.rdata[`CDAG_ST_HALT_BIT] = s_q.halt;
					s_d.rdata[`CDAG_ST_INTEN_BIT] = s_q.int_en;
					s_d.rdata[`CDAG_ST_BANK_BIT] = s_q.bank;
					s_d.rdata[`CDAG_ST_BUSY_BIT] = (s_q.st != cdag_pkg::cdag_st_idle);
					s_d.rdata[`CDAG_ST_ZSAVE_LSB +: 2] = s_q.zsave;
				end
				`CDAG_OFF_EA: s_d.rdata[12:0] = s_q.ea;
				`CDAG_OFF_OP: begin
					s_d.rdata[11:0] = s_q.word;
					s_d.rdata[`CDAG_OP_CYC_LSB +: 10] = s_q.cycles;
				end
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (apb_wr && apb_in.paddr == `CDAG_OFF_CTRL) begin
			s_d.cfg_8k = apb_in.pwdata[`CDAG_CTRL_CFG8K_BIT];
		end
		if (resume) begin
			s_d.halt = 1'b0;
		end
		case (s_q.st)
			cdag_pkg::cdag_st_idle: begin
				if (take) begin
					s_d.word = instr_word_in;
					s_d.pc = {s_q.cfg_8k & pc_in[12], pc_in[11:0]};
					s_d.dec = dec_new;
					s_d.ea = direct_addr;
					s_d.acc = (dec_new.gen_op == cdag_pkg::cdag_gn_acc_to_bank) ? acc_in : acc_new;
					s_d.acc_we = acc_we_new;
					s_d.skip = skip_new;
					s_d.cycles = cdag_cycles(dec_new);
					s_d.elapsed = 10'h001;
					tmr_load = 1'b1;
					// expiry is seen one edge before the done state, so load two less than the count
					tmr_val = cdag_cycles(dec_new) - 10'h002;
					if (dec_new.cls == cdag_pkg::cdag_cl_memref && dec_new.indirect) begin
						s_d.st = cdag_pkg::cdag_st_ind;
					end else begin
						s_d.st = cdag_pkg::cdag_st_exec;
					end
				end
			end
			cdag_pkg::cdag_st_ind: begin
				// one level only: the fetched word is final, never indirect again
				if (mem_ack_in) begin
					s_d.ea = {bank_eff, mem_rdata_in};
					s_d.st = cdag_pkg::cdag_st_exec;
				end
			end
			cdag_pkg::cdag_st_exec: begin
				if (tmr_expired) begin
					if (s_q.dec.cls == cdag_pkg::cdag_cl_generic &&
						s_q.dec.gen_op == cdag_pkg::cdag_gn_stall_online && !online_in) begin
						s_d.st = cdag_pkg::cdag_st_exec;
					end else begin
						s_d.st = cdag_pkg::cdag_st_done;
					end
				end
			end
			cdag_pkg::cdag_st_done: begin
				s_d.st = cdag_pkg::cdag_st_idle;
				if (s_q.dec.cls == cdag_pkg::cdag_cl_generic) begin
					case (s_q.dec.gen_op)
						cdag_pkg::cdag_gn_halt_op: s_d.halt = 1'b1;
						cdag_pkg::cdag_gn_acc_to_bank: s_d.bank = s_q.acc[0];
						cdag_pkg::cdag_gn_int_save: s_d.zsave = {s_q.pc[12], s_q.bank};
						cdag_pkg::cdag_gn_int_return: s_d.bank = s_q.zsave[0];
						cdag_pkg::cdag_gn_int_enable_op: s_d.int_en = 1'b1;
						cdag_pkg::cdag_gn_int_inhibit_op: s_d.int_en = 1'b0;
						default: s_d.halt = s_d.halt;
					endcase
				end
			end
			default: s_d.st = cdag_pkg::cdag_st_idle;
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
			s_q.cfg_8k <= `CDAG_CTRL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	cdag_timer #(
		.W(10)
	) u_timer (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.load_in(tmr_load),
		.load_val_in(tmr_val),
		.expired_out(tmr_expired)
	);

	// zero-wait slave; unmapped offsets answer with an error
	always_comb begin
		apb_out.pready = 1'b1;
		apb_out.prdata = s_q.rdata;
		apb_out.pslverr = apb_in.psel && apb_in.penable &&
			!(apb_in.paddr == `CDAG_OFF_CTRL || apb_in.paddr == `CDAG_OFF_STATUS ||
			apb_in.paddr == `CDAG_OFF_EA || apb_in.paddr == `CDAG_OFF_OP);
	end

	assign instr_ready_out = take;
	assign mem_rd_out = (s_q.st == cdag_pkg::cdag_st_ind);
	assign mem_addr_out = s_q.ea;
	assign done_out = (s_q.st == cdag_pkg::cdag_st_done);
	assign busy_out = (s_q.st != cdag_pkg::cdag_st_idle);
	assign dec_out = s_q.dec;
	assign ea_out = s_q.ea;
	assign acc_res_out = s_q.acc;
	assign acc_we_out = s_q.acc_we;
	assign skip_out = s_q.skip;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	localparam int bank_load_cyc = `CDAG_C_GEN_SHORT;

	sequence s_direct_done;
		done_out && s_q.dec.cls == cdag_pkg::cdag_cl_memref && !s_q.dec.indirect;
	endsequence
	sequence s_ind_fetch;
		mem_rd_out && mem_ack_in;
	endsequence

	AST_DIRECT_FIELD: assert property (s_direct_done |-> ea_out[6:0] == s_q.word[6:0])
		else $error("direct field not carried into address");
	AST_PRIMARY_SECTOR: assert property (s_direct_done and !s_q.dec.sector |-> ea_out[11:7] == 5'h00)
		else $error("sector bit zero left primary sector");
	AST_OWN_SECTOR: assert property (s_direct_done and s_q.dec.sector |-> ea_out[11:7] == s_q.pc[11:7])
		else $error("sector bit one missed own sector");
	AST_IND_WORD: assert property (s_ind_fetch |=> ea_out[11:0] == $past(mem_rdata_in) ##1 !mem_rd_out)
		else $error("indirect word not used as address");
	AST_DIRECT_BANK: assert property (s_direct_done |-> ea_out[12] == (s_q.cfg_8k & s_q.pc[12]))
		else $error("direct address left the instruction bank");
	AST_IND_BANK: assert property (s_ind_fetch |=> ea_out[12] == $past(s_q.cfg_8k & s_q.bank))
		else $error("indirect bank bit wrong");
	AST_TIME_EXACT: assert property (done_out && !s_q.dec.indirect &&
		s_q.dec.gen_op != cdag_pkg::cdag_gn_stall_online |-> s_q.elapsed == s_q.cycles)
		else $error("execution time differs from table");
	AST_TIME_LEAST: assert property (done_out |-> s_q.elapsed >= s_q.cycles)
		else $error("instruction completed early");
	AST_SHIFT_LOGICAL: assert property (take && dec_new.cls == cdag_pkg::cdag_cl_shift &&
		dec_new.shift_op == cdag_pkg::cdag_sh_logical_right_shift |=> acc_res_out == ($past(acc_in) >> $past(instr_word_in[3:0])))
		else $error("logical shift result wrong");
	AST_SKIP_MINUS: assert property (take && instr_word_in == 12'h081 |=> skip_out == $past(acc_in[11]))
		else $error("skip on minus wrong");
	AST_SET_MASK: assert property (take && instr_word_in == 12'h8c1 |=> dec_out.io_op == cdag_pkg::cdag_io_set_int_mask)
		else $error("set mask not decoded");
	AST_BANK_LOAD: assert property (take && instr_word_in == 12'h021 |-> ##bank_load_cyc done_out
		##1 s_q.bank == acc_res_out[0])
		else $error("bank register not loaded");
	AST_HALT_HOLDS: assert property (done_out && s_q.dec.gen_op == cdag_pkg::cdag_gn_halt_op &&
		s_q.dec.cls == cdag_pkg::cdag_cl_generic && !resume |=> !instr_ready_out [*2])
		else $error("halt did not stop issue");
endmodule : cdag_core

// ### verif/cdag_mem_model.sv
// behavioural core memory answering indirect word reads
`timescale 1ns/10ps
module cdag_mem_model (
	input wire logic clk_in, // cpu clock
	input wire logic reset_n_in, // master clear, active low
	input wire logic rd_in, // read request level
	input wire logic [12:0] addr_in, // word address
	input wire logic [3:0] delay_in, // wait cycles before answering
	output logic ack_out, // one-cycle answer
	output logic [11:0] rdata_out // read word
);
	logic [3:0] cnt_q;
	logic [11:0] word;
	// contents are a scramble of the address, bank bit included
	assign word = addr_in[11:0] ^ 12'ha5c ^ {12{addr_in[12]}};
	// released sense lines show the inverse so stale data never passes
	assign rdata_out = ack_out ? word : ~word;
	// answer once after the wait, slow or prompt as the bench asks
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_q <= 4'h0;
			ack_out <= 1'b0;
		end else begin
			ack_out <= rd_in && !ack_out && cnt_q >= delay_in;
			cnt_q <= (rd_in && !ack_out) ? cnt_q + 4'h1 : 4'h0;
		end
	end
endmodule : cdag_mem_model

// ### verif/cdag_core_bench.sv
// self-checking bench for the decode and address block
`timescale 1ns/10ps
module cdag_core_bench;
	logic clk_in = 0, reset_n_in = 0, valid = 0, ovf = 0, ack, rdy, mrd, done, busy, we, skip_always, err, bank = 0;
	logic [11:0] word = 0, acc = 0, rdata, res;
	logic [12:0] pc = 0, maddr, ea;
	logic [3:0] dly = 0;
	logic [31:0] seed = 32'h5a22ffa0, rd, r;
	int fail_count = 0, checked = 0;
	logic k8 = 0, online = 1;
	logic [11:0] gen_codes [11] = '{12'h8c1, 12'h003, 12'h005, 12'h011, 12'h012, 12'h014, 12'h018,
		12'h022, 12'h028, 12'h024, 12'h030};
	cdag_pkg::cdag_apb_req_t apb = '0;
	cdag_pkg::cdag_apb_rsp_t rsp;
	cdag_pkg::cdag_dec_t dec;
	cdag_core cdag_core_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .apb_in(apb), .apb_out(rsp),
		.instr_valid_in(valid), .instr_ready_out(rdy), .instr_word_in(word), .pc_in(pc), .acc_in(acc),
		.overflow_in(ovf), .online_in(online), .mem_rd_out(mrd), .mem_addr_out(maddr), .mem_ack_in(ack),
		.mem_rdata_in(rdata), .done_out(done), .busy_out(busy), .dec_out(dec), .ea_out(ea),
		.acc_res_out(res), .acc_we_out(we), .skip_out(skip_always));
	cdag_mem_model cdag_mem_model_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .rd_in(mrd), .addr_in(maddr),
		.delay_in(dly), .ack_out(ack), .rdata_out(rdata));
	// 40 MHz clock
	initial forever #12.5 clk_in = ~clk_in;
	// expectation helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int cyc(logic [11:0] w);
		int ns;
		if (w[10:8] != 3'h0) begin
			ns = w[10:8] < 3'h4 ? 3390 : w[10:8] < 3'h6 ? 7630 : w[10:8] == 3'h6 ? 9330 : 4660;
			ns += w[11] ? (w[10:8] == 3'h6 ? 1690 : 1700) : 0;
		end else if (w[11]) ns = 4660;
		else if (w[7:6] == 2'h1) ns = 3400 + 424 * w[3:0];
		else if (w[7] || w[5:0] inside {6'h11, 6'h12, 6'h14, 6'h18}) ns = 3390;
		else if (w[5:0] inside {6'h03, 6'h05}) ns = 7630;
		else ns = 2540;
		return (ns * 40 + 999) / 1000;
	endfunction : cyc
	function automatic logic [12:0] ea_exp(logic [11:0] w, logic [12:0] p);
		logic [12:0] d;
		d = {k8 & p[12], w[7] ? p[11:7] : 5'h00, w[6:0]};
		return w[11] ? {k8 & bank, d[11:0] ^ 12'ha5c ^ {12{d[12]}}} : d;
	endfunction : ea_exp
	function automatic logic [11:0] acc_exp(logic [11:0] w, logic [11:0] a);
		logic [35:0] t;
		t = {a, a, a} >> w[3:0];
		if (w[7:4] == 4'h4) return a >> w[3:0];
		if (w[7:4] == 4'h5) return $signed(a) >>> w[3:0];
		if (w[7:4] == 4'h6) return t[11:0];
		case (w[5:0])
			6'h03: return ~a;
			6'h05: return -a;
			6'h18: return {11'h000, ovf};
			6'h12: return {11'h000, k8 & bank};
			default: return 12'h000;
		endcase
	endfunction : acc_exp
	function automatic logic skp_exp(logic [11:0] w, logic [11:0] a);
		logic t;
		t = w[2:0] == 3'h1 ? a[11] : w[2:0] == 3'h2 ? a == 0 : w[2:0] == 3'h3 ? a[11] | a == 0 : w[2:0] == 3'h4 && ovf;
		return t ^ w[6];
	endfunction : skp_exp
	// comparison, verdict and hang exit
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	task automatic bail();
		fail_count++;
		wrap_up();
	endtask : bail
	// one apb transfer: setup, then access until pready
	task automatic apb_xfer(logic w, logic [11:0] a, logic [31:0] d);
		int n = 0;
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_in);
		apb.penable <= 1'b1;
		do begin @(posedge clk_in); n++; end while (!rsp.pready && n < 9);
		if (!rsp.pready) bail();
		rd = rsp.prdata;
		err = rsp.pslverr;
		apb <= '0;
		@(posedge clk_in);
	endtask : apb_xfer
	// offer one instruction, time it, check what it produced
	task automatic exec(logic [11:0] w, logic [12:0] p, logic [11:0] a);
		int n = 0;
		r = rnd();
		word <= w;
		pc <= p;
		acc <= a;
		ovf <= r[4];
		dly <= r[3:0];
		online <= (w != 12'h011);
		valid <= 1'b1;
		do begin @(posedge clk_in); n++; end while (!rdy && n < 9);
		if (!rdy) bail();
		valid <= 1'b0;
		n = 0;
		// stall op: on-line comes late, done follows two edges after it is seen
		do begin @(posedge clk_in); n++; if (n == cyc(w) + 4) online <= 1'b1; end while (!done && n < 600);
		chk("cycles", n, cyc(w) + (w == 12'h011 ? 6 : 0));
		chk("busy", busy, 32'h1);
		chk("acc_we", we, w[11:8] == 4'h0 && (w[7:6] == 2'h1 ||
			w[7:6] == 2'h0 && w[5:0] inside {6'h03, 6'h05, 6'h12, 6'h18, 6'h30}));
		if (w[10:8] != 3'h0) begin
			chk("ea", ea, ea_exp(w, p));
			chk("mr_op", dec.mr_op, w[10:8]);
		end else if (w[11]) chk("io_op", dec.io_op, w == 12'h8c1 ? 3'h4 : w[7:6]);
		else if (w[7:6] == 2'h1) chk("shift", res, acc_exp(w, acc));
		else if (w[7]) chk("skip", skip_always, skp_exp(w, acc));
		else if (w[5:0] inside {6'h03, 6'h05, 6'h12, 6'h18, 6'h30}) chk("acc", res, acc_exp(w, acc));
		if (w == 12'h021) bank = acc[0];
	endtask : exec
	// main sequence
	initial begin
		repeat (16) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		apb_xfer(1'b0, 12'h004, 32'h0);
		chk("status", rd, 32'h0);
		apb_xfer(1'b0, 12'h010, 32'h0);
		chk("slverr", err, 32'h1);
		for (int i = 0; i < 100; i++) begin
			if (i == 40) k8 = 1'b1;
			if (i == 40) apb_xfer(1'b1, 12'h000, 32'h1);
			r = rnd();
			if (k8 && i % 4 == 0) exec(12'h021, r[28:16], r[27:16]);
			else exec({r[11], 3'(r[10:8] % 7 + 1), r[7:0]}, r[28:16], r[27:16]);
		end
		for (int s = 0; s < 5; s++) begin
			r = rnd();
			exec(12'h080 + 12'(s), 13'h0, 12'h000);
			exec(12'h0c0 + 12'(s), 13'h0, r[11:0]);
			exec(12'h800 + {r[7:6], 6'h00}, 13'h0, r[11:0]);
			exec(12'h040 + {r[5:4] % 2'h3, r[3:0]}, 13'h0, r[27:16]);
		end
		foreach (gen_codes[k]) exec(gen_codes[k], 13'h0, r[11:0]);
		exec(12'h000, 13'h0, 12'h0);
		valid <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk("ready while halted", rdy, 32'h0);
		valid <= 1'b0;
		apb_xfer(1'b1, 12'h000, 32'h3);
		apb_xfer(1'b0, 12'h004, 32'h0);
		chk("halt cleared", rd[0], 32'h0);
		chk("status end", rd, {26'h0, 1'b0, bank, 1'b0, bank, 1'b1, 1'b0});
		wrap_up();
	end
endmodule : cdag_core_bench
